//--- bench/snrx_fabric_model.sv
// Fabric-side consumer of the regenerated parallel stream
`timescale 1ns/1ps
module snrx_fabric_model (
  input  wire logic       clk,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic      [31:0] taken,
  output logic      [7:0]  sum
);
  initial begin
    taken = 32'h0;
    sum = 8'h0;
  end
  // Marker ignored on purpose: generic data needs only the valid flag
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      taken <= taken + 32'h1;
      sum <= sum ^ data;
    end
  end
endmodule

//--- bench/testbench.sv
// Random and corner-case bench for the receive overhead and alignment block
`timescale 1ns/1ps
module testbench;
  import snrx_pkg::*;
  logic CLK, RST_N, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, LINE_FP, LINE_LOF, PAR_VALID, PAR_MARK, PAR_FP;
  logic TOH_SDATA, TOH_SFP, TOH_SEN, kpass, run, v_q, v2, wait_n;
  logic [7:0] AVS_ADDRESS, LINE_DATA, LINE_H1, LINE_H2, LINE_K1, LINE_K2, LINE_TOH_RAW, PAR_DATA, LNK_FP, ALN_SYNCED;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rnd, rd;
  logic [NUM_LINKS-1:0][7:0] LNK_DATA;
  snrx_path_t LINE_PATH;
  snrx_entry_t [NUM_LINKS-1:0] ALN_OUT;
  logic [10:0] col, e_q, e2;
  logic [3:0] row;
  int bad_count, compares;
  snrx_align u_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINE_FP(LINE_FP), .LINE_DATA(LINE_DATA), .LINE_PATH(LINE_PATH),
    .LINE_H1(LINE_H1), .LINE_H2(LINE_H2), .LINE_K1(LINE_K1), .LINE_K2(LINE_K2), .LINE_TOH_RAW(LINE_TOH_RAW),
    .LINE_LOF(LINE_LOF), .PAR_DATA(PAR_DATA), .PAR_VALID(PAR_VALID), .PAR_MARK(PAR_MARK), .PAR_FP(PAR_FP),
    .TOH_SDATA(TOH_SDATA), .TOH_SFP(TOH_SFP), .TOH_SEN(TOH_SEN), .LNK_FP(LNK_FP), .LNK_DATA(LNK_DATA),
    .ALN_OUT(ALN_OUT), .ALN_SYNCED(ALN_SYNCED));
  snrx_fabric_model u_fabric (.clk(CLK), .valid(PAR_VALID), .data(PAR_DATA), .taken(), .sum());
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected {valid, marker, byte} for one position of the frame
  function automatic logic [9:0] f_exp(input logic [3:0] r, input logic [10:0] c, input logic [31:0] x,
    input logic kp);
    snrx_path_t p;
    p = snrx_path_t'(x[13:8]);
    if (c >= TOH_COLS) return {p.payload_valid_flag & !p.pos_just, p.payload_valid_flag & p.j1 & p.head & !p.ais_p, x[7:0]};
    if (r == ROW_FRAMING) return (c < COL_GRP2) ? {2'b00, A1_VAL} : (c < COL_GRP3) ? {2'b00, A2_VAL} :
      {1'b0, c == COL_GRP3, 8'h00};
    if (r == ROW_POINTER) return (c < COL_GRP2) ? {2'b00, p.ais_p ? ONES_BYTE : x[21:14]} :
      (c < COL_GRP3) ? {2'b00, p.ais_p ? ONES_BYTE : x[29:22]} : {p.neg_just, 1'b0, p.neg_just ? x[7:0] : 8'h00};
    if (r == ROW_APS && kp && c == COL_GRP2) return {2'b00, x[23:16]};
    if (r == ROW_APS && kp && c == COL_GRP3) return {2'b00, x[31:24]};
    return 10'h000;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus master: hold request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK); while (wait_n !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // Waitrequest as it stands just before each rising edge
  always @(negedge CLK) wait_n <= AVS_WAITREQUEST;
  task automatic lnk(input logic [7:0] m);
    @(posedge CLK);
    LNK_FP <= m;
    @(posedge CLK);
    LNK_FP <= 8'h00;
  endtask
  task automatic complete_run;
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // Random line and link bytes; expectation piped two clocks to meet the output
  always @(posedge CLK) begin
    if (run) begin
      rnd = lfsr(rnd);
      {LINE_K2, LINE_K1} <= rnd[31:16];
      LINE_DATA <= rnd[7:0];
      LINE_PATH <= snrx_path_t'(rnd[13:8]);
      LINE_H1 <= rnd[21:14];
      LINE_H2 <= rnd[29:22];
      LINE_TOH_RAW <= rnd[15:8];
      LNK_DATA <= {rnd, ~rnd};
      LINE_FP <= (row == 4'h0 && col == 11'h0);
      e_q <= {row == 4'h0 && col == 11'h0, f_exp(row, col, rnd, kpass)};
      v_q <= v_q | (row == 4'h0 && col == 11'h1); // Design counters align on the first pulse
      col <= (col == COL_LAST) ? 11'h0 : col + 11'h1;
      if (col == COL_LAST) row <= (row == ROW_LAST) ? 4'h0 : row + 4'h1;
    end
    e2 <= e_q;
    v2 <= v_q;
  end
  always @(negedge CLK) if (v2) check({PAR_FP, PAR_VALID, PAR_MARK, PAR_DATA}, e2);
  initial begin
    repeat (40000) @(posedge CLK);
    bad_count++;
    complete_run();
  end
  initial begin
    {RST_N, AVS_READ, AVS_WRITE, LINE_FP, LINE_LOF, LNK_FP, kpass, run, v_q, v2, col, row, e_q} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA, LINE_DATA, LINE_H1, LINE_H2, LINE_K1, LINE_K2, LINE_TOH_RAW} = '0;
    {LINE_PATH, LNK_DATA} = '0;
    CE = 1'b1;
    rnd = 32'h85345ed2;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    bus(1'b0, REG_ENABLE, 32'h0); check(rd, 32'hff);
    bus(1'b0, 8'hfc, 32'h0); check(rd, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    kpass = 1'b1;
    run = 1'b1;
    repeat (11000) @(posedge CLK);
    while (row != 4'h1) @(posedge CLK);
    bus(1'b1, REG_CTRL, 32'h0);
    kpass = 1'b0;
    bus(1'b1, REG_MODE, 32'hffff);
    bus(1'b1, REG_RESYNC, 32'hff);
    lnk(8'hff);
    repeat (10) @(negedge CLK);
    check(ALN_SYNCED, 32'h0);
    repeat (10) @(negedge CLK);
    check(ALN_SYNCED, 32'hff);
    check(ALN_OUT[0].vld, 32'h1);
    lnk(8'h01);
    repeat (4) @(negedge CLK);
    check(ALN_SYNCED, 32'hff);
    bus(1'b0, REG_STATUS, 32'h0); check(rd[15:0], 32'hff00);
    bus(1'b1, REG_RESYNC, 32'hff);
    lnk(8'h01);
    repeat (25) @(posedge CLK);
    lnk(8'hfe);
    repeat (30) @(posedge CLK);
    bus(1'b0, REG_STATUS, 32'h0); check(rd[0], 32'h1);
    repeat (9800) @(posedge CLK);
    complete_run();
  end
endmodule

//--- inc/snrx_pkg.sv
// Constants and carrier types for the receive overhead and link alignment block
// Overview of operation
// - Framing bytes always regenerated as F6 and 28
// - Protection bytes passed or zeroed by software
// - Pointer bytes regenerated, other overhead zero
// - H3 slot carries line data on negative stuff
// - Serial drop sends overhead as received, MSB first
// - First framing bit replaced by even parity
// - Line AIS forces every serial drop bit high
// - Marker once per frame at section trace
// - Marker with valid at each J1 position
// - Valid high only for payload carrying data
// - No J1 marker under path AIS
// - Concatenated group marks only its head
// - Valid follows negative and positive justification
// - J1 marker follows every pointer movement
// - Per-link 24-entry by 10-bit alignment FIFO
// - Groupings: slice, both slices, twin, independent
// - Disabled streams never affect group synchronisation
// - Flag error when pulses over 19 apart
// - Sync once; later resync only by software
// - Count 24 down by one, then two
// - Aligned group starts reading together at zero
// - Frame pulses last exactly one clock
package snrx_pkg;
  localparam int unsigned NUM_LINKS     = 8;       // Aligned streams
  localparam int unsigned FIFO_DEPTH    = 24;      // Entries per link
  localparam logic [4:0]  FIFO_LAST     = 5'h17;   // Last FIFO index
  localparam logic [5:0]  ALN_START     = 6'h18;   // Alignment count start
  localparam logic [4:0]  ALN_ERR_SPAN  = 5'h12;   // Largest legal pulse spread less one
  localparam logic [10:0] COL_LAST      = 11'h437; // Last byte column of a row
  localparam logic [3:0]  ROW_LAST      = 4'h8;    // Last row of a frame
  localparam logic [10:0] TOH_COLS      = 11'h024; // Overhead columns per row
  localparam logic [8:0]  TOH_BITS_LAST = 9'h11f;  // Last overhead bit of a row
  localparam logic [3:0]  ROW_FRAMING   = 4'h0;    // Row with A1, A2, J0
  localparam logic [3:0]  ROW_POINTER   = 4'h3;    // Row with H1, H2, H3
  localparam logic [3:0]  ROW_APS       = 4'h4;    // Row with K1, K2
  localparam logic [10:0] COL_GRP2      = 11'h00c; // Start of second column group
  localparam logic [10:0] COL_GRP3      = 11'h018; // Start of third column group
  localparam logic [7:0]  A1_VAL        = 8'hf6;   // First framing byte
  localparam logic [7:0]  A2_VAL        = 8'h28;   // Second framing byte
  localparam logic [7:0]  ONES_BYTE     = 8'hff;   // AIS fill
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_MODE      = 8'h04;
  localparam logic [7:0]  REG_ENABLE    = 8'h08;
  localparam logic [7:0]  REG_RESYNC    = 8'h0c;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  localparam int unsigned CTRL_KPASS    = 0;       // Pass K1/K2 through
  localparam int unsigned CTRL_AISF     = 1;       // Force line AIS
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [15:0] MODE_RST      = 16'h0000;
  localparam logic [7:0]  ENABLE_RST    = 8'hff;

  // Alignment grouping per link
  typedef enum logic [1:0] {
    GRP_SOLO  = 2'b00,
    GRP_TWIN  = 2'b01,
    GRP_SLICE = 2'b10,
    GRP_ALL   = 2'b11
  } snrx_grp_t;

  // Per-link read control state
  typedef enum logic [1:0] {
    ALN_IDLE  = 2'b00,
    ALN_COUNT = 2'b01,
    ALN_READ  = 2'b10
  } snrx_aln_t;

  // Path information from the pointer stage, one per byte
  typedef struct packed {
    logic payload_valid_flag;       // Byte lies in the payload envelope
    logic j1;        // Byte is a path overhead J1
    logic ais_p;     // Path AIS on this STS-1
    logic head;      // STS-1 heads its concatenation group
    logic neg_just;  // Negative justification this frame
    logic pos_just;  // Positive stuff byte carries no data
  } snrx_path_t;

  // One alignment FIFO entry, ten bits
  typedef struct packed {
    logic       vld;
    logic       fp;
    logic [7:0] data;
  } snrx_entry_t;
endpackage

//--- rtl/snrx_align.sv
// Receive overhead regeneration, serial drop and multi-link frame alignment
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module snrx_align
  import snrx_pkg::*;
(
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  input  wire logic                      CE,
  input  wire logic [7:0]                AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  output logic      [31:0]               AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  input  wire logic                      LINE_FP,
  input  wire logic [7:0]                LINE_DATA,
  input  wire snrx_path_t                LINE_PATH,
  input  wire logic [7:0]                LINE_H1,
  input  wire logic [7:0]                LINE_H2,
  input  wire logic [7:0]                LINE_K1,
  input  wire logic [7:0]                LINE_K2,
  input  wire logic [7:0]                LINE_TOH_RAW,
  input  wire logic                      LINE_LOF,
  output logic      [7:0]                PAR_DATA,
  output logic                           PAR_VALID,
  output logic                           PAR_MARK,
  output logic                           PAR_FP,
  output logic                           TOH_SDATA,
  output logic                           TOH_SFP,
  output logic                           TOH_SEN,
  input  wire logic [NUM_LINKS-1:0]      LNK_FP,
  input  wire logic [NUM_LINKS-1:0][7:0] LNK_DATA,
  output snrx_entry_t [NUM_LINKS-1:0]    ALN_OUT,
  output logic      [NUM_LINKS-1:0]      ALN_SYNCED
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [1:0]           ctrl_q;      // Protection pass, AIS force
  logic [15:0]          mode_q;      // Two grouping bits per link
  logic [NUM_LINKS-1:0] enable_q;    // Link enables
  logic [NUM_LINKS-1:0] resync_q;    // One-clock resync pulses
  logic [NUM_LINKS-1:0] err_q;       // Sticky alignment errors
  logic [NUM_LINKS-1:0] err_set;     // Error events from read controls
  logic                 ack_q;       // Answer cycle of a bus access
  logic                 req;         // Any access pending
  logic                 wr_take;     // Write takes effect now

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_take         = CE & AVS_WRITE & ack_q;

  // One wait state: request seen, then answered next edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else if (CE) begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data captured in the wait cycle, stands through the answer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (CE && AVS_READ && !ack_q) begin
      unique case (AVS_ADDRESS)
        REG_CTRL:   AVS_READDATA <= {30'h0000_0000, ctrl_q};
        REG_MODE:   AVS_READDATA <= {16'h0000, mode_q};
        REG_ENABLE: AVS_READDATA <= {24'h00_0000, enable_q};
        REG_STATUS: AVS_READDATA <= {16'h0000, ALN_SYNCED, err_q};
        default:    AVS_READDATA <= 32'h0000_0000; // Unmapped and resync read zero
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q   <= CTRL_RST;
      mode_q   <= MODE_RST;
      enable_q <= ENABLE_RST;
    end else if (wr_take) begin
      if (AVS_ADDRESS == REG_CTRL) begin
        ctrl_q <= AVS_WRITEDATA[1:0];
      end
      if (AVS_ADDRESS == REG_MODE) begin
        mode_q <= AVS_WRITEDATA[15:0];
      end
      if (AVS_ADDRESS == REG_ENABLE) begin
        enable_q <= AVS_WRITEDATA[NUM_LINKS-1:0];
      end
    end
  end

  // Resync strobes; only software can realign after start-up
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      resync_q <= '0;
    end else if (CE) begin
      resync_q <= (wr_take && AVS_ADDRESS == REG_RESYNC) ? AVS_WRITEDATA[NUM_LINKS-1:0] : '0;
    end
  end

  // Sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      err_q <= '0;
    end else if (CE) begin
      if (wr_take && AVS_ADDRESS == REG_STATUS) begin
        err_q <= (err_q & ~AVS_WRITEDATA[NUM_LINKS-1:0]) | err_set;
      end else begin
        err_q <= err_q | err_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position counters
  logic [10:0] col_q;     // Byte column in the row
  logic [3:0]  row_q;     // Row in the frame
  logic        in_toh;    // Overhead column
  logic        ais_l;     // Line AIS, lost frame or forced

  assign in_toh = col_q < TOH_COLS;
  assign ais_l  = LINE_LOF | ctrl_q[CTRL_AISF];

  // Line frame pulse marks A1 of STS-1 one
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      col_q <= 11'h000;
      row_q <= 4'h0;
    end else if (CE) begin
      if (LINE_FP) begin
        col_q <= 11'h001; // Pulse byte is column zero
        row_q <= 4'h0;
      end else if (col_q == COL_LAST) begin
        col_q <= 11'h000;
        row_q <= (row_q == ROW_LAST) ? 4'h0 : row_q + 4'h1;
      end else begin
        col_q <= col_q + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel output bus
  logic       a1_slot, a2_slot, j0_slot, h1_slot, h2_slot, h3_slot, k1_slot, k2_slot;
  logic [7:0] par_d;     // Next output byte
  logic       vld_d;     // Next payload valid
  logic       mark_d;    // Next marker

  assign a1_slot = row_q == ROW_FRAMING && col_q < COL_GRP2;
  assign a2_slot = row_q == ROW_FRAMING && col_q >= COL_GRP2 && col_q < COL_GRP3;
  assign j0_slot = row_q == ROW_FRAMING && col_q == COL_GRP3;
  assign h1_slot = row_q == ROW_POINTER && col_q < COL_GRP2;
  assign h2_slot = row_q == ROW_POINTER && col_q >= COL_GRP2 && col_q < COL_GRP3;
  assign h3_slot = row_q == ROW_POINTER && col_q >= COL_GRP3 && in_toh;
  assign k1_slot = row_q == ROW_APS && col_q == COL_GRP2;
  assign k2_slot = row_q == ROW_APS && col_q == COL_GRP3;

  // Overhead regeneration and payload flags
  always_comb begin
    par_d  = 8'h00;   // Unlisted overhead bytes are zero
    vld_d  = 1'b0;
    mark_d = 1'b0;
    if (!in_toh) begin
      par_d  = LINE_DATA;
      vld_d  = LINE_PATH.payload_valid_flag & ~LINE_PATH.pos_just;
      mark_d = LINE_PATH.payload_valid_flag & LINE_PATH.j1 & LINE_PATH.head & ~LINE_PATH.ais_p;
    end else if (a1_slot) begin
      par_d = A1_VAL;
    end else if (a2_slot) begin
      par_d = A2_VAL;
    end else if (j0_slot) begin
      mark_d = 1'b1;  // Section trace of STS-1 one
    end else if (h1_slot) begin
      par_d = LINE_PATH.ais_p ? ONES_BYTE : LINE_H1; // SS bits ride through
    end else if (h2_slot) begin
      par_d = LINE_PATH.ais_p ? ONES_BYTE : LINE_H2;
    end else if (h3_slot) begin
      par_d = LINE_PATH.neg_just ? LINE_DATA : 8'h00;
      vld_d = LINE_PATH.neg_just;
    end else if (k1_slot) begin
      par_d = ctrl_q[CTRL_KPASS] ? LINE_K1 : 8'h00;
    end else if (k2_slot) begin
      par_d = ctrl_q[CTRL_KPASS] ? LINE_K2 : 8'h00;
    end
  end

  // Output bus registered, one clock behind the counters
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PAR_DATA  <= 8'h00;
      PAR_VALID <= 1'b0;
      PAR_MARK  <= 1'b0;
      PAR_FP    <= 1'b0;
    end else if (CE) begin
      PAR_DATA  <= par_d;
      PAR_VALID <= vld_d;
      PAR_MARK  <= mark_d;
      PAR_FP    <= row_q == ROW_FRAMING && col_q == 11'h000; // Single clock
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial overhead drop: one row buffered, sent during payload time
  logic [7:0] toh_buf [TOH_COLS];  // Row of received overhead
  logic [8:0] bit_q;               // Bit being sent
  logic       sh_act_q;            // Shifting a row
  logic       par_acc_q;           // Parity of this frame so far
  logic       par_prev_q;          // Parity of the previous frame
  logic [7:0] sh_byte;             // Byte under the shifter

  assign sh_byte = toh_buf[bit_q[8:3]];

  // Store overhead bytes exactly as received
  always_ff @(posedge CLK) begin
    if (CE && in_toh) begin
      toh_buf[col_q[5:0]] <= LINE_TOH_RAW;
    end
  end

  // Even parity over the whole overhead of a frame
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      par_acc_q  <= 1'b0;
      par_prev_q <= 1'b0;
    end else if (CE && in_toh) begin
      if (row_q == ROW_FRAMING && col_q == 11'h000) begin
        par_prev_q <= par_acc_q;
        par_acc_q  <= ^LINE_TOH_RAW;
      end else begin
        par_acc_q  <= par_acc_q ^ (^LINE_TOH_RAW);
      end
    end
  end

  // Row shifter starts when the overhead columns end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sh_act_q <= 1'b0;
      bit_q    <= 9'h000;
    end else if (CE) begin
      if (col_q == TOH_COLS) begin
        sh_act_q <= 1'b1;
        bit_q    <= 9'h000;
      end else if (sh_act_q) begin
        sh_act_q <= bit_q != TOH_BITS_LAST;
        bit_q    <= bit_q + 9'h001;
      end
    end
  end

  // Serial outputs, MSB first; AIS gives all ones, parity included
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TOH_SDATA <= 1'b0;
      TOH_SFP   <= 1'b0;
      TOH_SEN   <= 1'b0;
    end else if (CE) begin
      TOH_SEN <= sh_act_q;
      TOH_SFP <= sh_act_q && bit_q == 9'h000;
      if (!sh_act_q) begin
        TOH_SDATA <= 1'b0;
      end else if (ais_l) begin
        TOH_SDATA <= 1'b1;
      end else if (row_q == ROW_FRAMING && bit_q == 9'h000) begin
        TOH_SDATA <= par_prev_q;
      end else begin
        TOH_SDATA <= sh_byte[3'h7 - bit_q[2:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link inputs come from pins: two flops before any use
  logic [NUM_LINKS-1:0]      fp_m_q, fp_s_q;
  logic [NUM_LINKS-1:0][7:0] dat_m_q, dat_s_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fp_m_q  <= '0;
      fp_s_q  <= '0;
      dat_m_q <= '0;
      dat_s_q <= '0;
    end else if (CE) begin
      fp_m_q  <= LNK_FP;
      fp_s_q  <= fp_m_q;
      dat_m_q <= LNK_DATA;
      dat_s_q <= dat_m_q;
    end
  end

  // Group members of a link, by its own grouping
  function automatic logic [NUM_LINKS-1:0] grp_mask(input int unsigned idx, input logic [1:0] mode);
    logic [NUM_LINKS-1:0] m;
    m = '0;
    for (int unsigned j = 0; j < NUM_LINKS; j++) begin
      unique case (snrx_grp_t'(mode))
        GRP_SOLO:  m[j] = j == idx;
        GRP_TWIN:  m[j] = (j >> 1) == (idx >> 1);
        GRP_SLICE: m[j] = (j >> 2) == (idx >> 2);
        GRP_ALL:   m[j] = 1'b1;
      endcase
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-link FIFO, write control and read control
  for (genvar i = 0; i < NUM_LINKS; i++) begin : g_link
    snrx_entry_t          mem_q [FIFO_DEPTH]; // 24 x 10 bits
    logic [4:0]           wr_q;               // Write index
    logic [4:0]           rd_q;               // Read index
    snrx_aln_t            st_q;               // Read control state
    logic [5:0]           cnt_q;              // Alignment count
    logic [4:0]           span_q;             // Clocks since first pulse
    logic [NUM_LINKS-1:0] seen_q;             // Members that pulsed
    logic [NUM_LINKS-1:0] mask;               // Enabled group members
    logic [NUM_LINKS-1:0] pls;                // Member pulses this clock
    logic                 all_in;             // Every member has pulsed
    logic [5:0]           step;               // Decrement this clock

    // Disabled links and links in another mode stay out of the group
    always_comb begin
      mask = '0;
      for (int unsigned j = 0; j < NUM_LINKS; j++) begin
        mask[j] = grp_mask(i, mode_q[2*i +: 2])[j] & enable_q[j]
                  & (mode_q[2*j +: 2] == mode_q[2*i +: 2]);
      end
    end
    assign pls    = fp_s_q & mask;
    assign all_in = ((seen_q | pls) & mask) == mask;
    assign step   = all_in ? 6'h02 : 6'h01;

    // Frame byte always lands at index zero
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        wr_q <= 5'h00;
      end else if (CE) begin
        if (fp_s_q[i]) begin
          wr_q <= 5'h01;
        end else begin
          wr_q <= (wr_q == FIFO_LAST) ? 5'h00 : wr_q + 5'h01;
        end
      end
    end

    // FIFO storage with the frame bit beside each byte
    always_ff @(posedge CLK) begin
      if (CE) begin
        mem_q[fp_s_q[i] ? 5'h00 : wr_q] <= '{vld: 1'b1, fp: fp_s_q[i], data: dat_s_q[i]};
      end
    end

    // Read control: armed once after reset, re-armed only by resync
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        st_q   <= ALN_IDLE;
        cnt_q  <= ALN_START;
        seen_q <= '0;
      end else if (CE) begin
        if (resync_q[i]) begin
          st_q   <= ALN_IDLE;                   // Data in flight is lost
          seen_q <= '0;
        end else begin
          unique case (st_q)
            ALN_IDLE: if (|pls) begin
              st_q   <= ALN_COUNT;
              cnt_q  <= ALN_START - step;
              seen_q <= pls;
            end
            ALN_COUNT: begin
              seen_q <= seen_q | pls;
              cnt_q  <= cnt_q - step;
              if (cnt_q <= step) begin
                st_q <= ALN_READ;               // Whole group leaves together
              end
            end
            ALN_READ: st_q <= ALN_READ;         // No automatic resync
            default:  st_q <= ALN_IDLE;
          endcase
        end
      end
    end

    // Spread counter for the pulse window
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        span_q <= 5'h00;
      end else if (CE) begin
        if (st_q == ALN_IDLE) begin
          span_q <= 5'h00;
        end else if (st_q == ALN_COUNT && !all_in && span_q <= ALN_ERR_SPAN) begin
          span_q <= span_q + 5'h01;
        end
      end
    end
    assign err_set[i] = CE && enable_q[i] && st_q == ALN_COUNT && !all_in && span_q == ALN_ERR_SPAN;

    // Read index starts at zero on release
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        rd_q <= 5'h00;
      end else if (CE) begin
        if (st_q != ALN_READ) begin
          rd_q <= 5'h00;
        end else begin
          rd_q <= (rd_q == FIFO_LAST) ? 5'h00 : rd_q + 5'h01;
        end
      end
    end

    // Aligned output registered
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        ALN_OUT[i] <= '0;
      end else if (CE) begin
        ALN_OUT[i] <= (st_q == ALN_READ && !resync_q[i]) ? mem_q[rd_q] : '0;
      end
    end
    assign ALN_SYNCED[i] = st_q == ALN_READ;

    rd_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && st_q == ALN_COUNT && cnt_q <= step && !resync_q[i]) |=> (st_q == ALN_READ && rd_q == 5'h00))
      else $error("read did not start at index zero");
    // Frozen clocks stretch the wait and a resync in the window restarts it, so they end the check
    align_wait_a: assert property (@(posedge CLK) disable iff (!RST_N || !CE || resync_q[i])
      (st_q == ALN_IDLE && pls == mask && mask != '0) |-> ##12 st_q == ALN_READ)
      else $error("aligned pulses did not wait twelve clocks");
    align_err_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && enable_q[i] && st_q == ALN_COUNT && !all_in && span_q == ALN_ERR_SPAN && !resync_q[i])
      |=> err_q[i])
      else $error("pulse spread over limit not flagged");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the overhead and serial paths
  framing_byte_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !LINE_FP && row_q == ROW_FRAMING && col_q == 11'h000) |=> PAR_DATA == A1_VAL)
    else $error("first framing byte wrong");
  aps_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !LINE_FP && k1_slot && !ctrl_q[CTRL_KPASS]) |=> PAR_DATA == 8'h00)
    else $error("protection byte not zeroed");
  h3_fill_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !LINE_FP && h3_slot && !LINE_PATH.neg_just) |=> (PAR_DATA == 8'h00 && !PAR_VALID))
    else $error("H3 slot not zero without stuffing");
  trace_mark_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !LINE_FP && j0_slot) |=> (PAR_MARK && !PAR_VALID))
    else $error("section trace marker missing");
  path_ais_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && !LINE_FP && !in_toh && LINE_PATH.ais_p) |=> !PAR_MARK)
    else $error("J1 marker under path AIS");
  ais_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && sh_act_q && ais_l) |=> TOH_SDATA)
    else $error("serial drop not all ones under AIS");
  frame_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && PAR_FP) |=> !PAR_FP)
    else $error("frame pulse longer than one clock");

endmodule
